// ===== tsr_map.vh
// Register offsets, reset values, field positions and constants of the sensor register bank
`ifndef TSR_MAP_VH
`define TSR_MAP_VH

// Register offsets seen through the pointer
`define TSR_ADDR_RES_HI 8'h00
`define TSR_ADDR_RES_LO 8'h01
`define TSR_ADDR_STATUS 8'h02
`define TSR_ADDR_CONFIG 8'h03
`define TSR_ADDR_UP_HI 8'h04
`define TSR_ADDR_UP_LO 8'h05
`define TSR_ADDR_BOT_HI 8'h06
`define TSR_ADDR_BOT_LO 8'h07
`define TSR_ADDR_SEV_HI 8'h08
`define TSR_ADDR_SEV_LO 8'h09
`define TSR_ADDR_MARGIN 8'h0a
`define TSR_ADDR_IDENT 8'h0b
`define TSR_ADDR_RSV_A 8'h0c
`define TSR_ADDR_RSV_B 8'h0d
`define TSR_ADDR_RSV_C 8'h2e
`define TSR_ADDR_SOFT_RST 8'h2f

// Power-on values
`define TSR_RST_POINTER 8'h00
`define TSR_RST_RESULT 16'h0000
`define TSR_RST_STATUS 8'h00
`define TSR_RST_CONFIG 8'h00
`define TSR_RST_UP_HI 8'h20
`define TSR_RST_UP_LO 8'h00
`define TSR_RST_BOT_HI 8'h05
`define TSR_RST_BOT_LO 8'h00
`define TSR_RST_SEV_HI 8'h49
`define TSR_RST_SEV_LO 8'h80
`define TSR_RST_MARGIN 8'h05
`define TSR_RSV_READ 8'h00

// Writable bank: eight bytes from the configuration offset upward
`define TSR_NUM_WR 8
`define TSR_RST_WR_ALL {`TSR_RST_MARGIN, `TSR_RST_SEV_LO, `TSR_RST_SEV_HI, `TSR_RST_BOT_LO, \
	`TSR_RST_BOT_HI, `TSR_RST_UP_LO, `TSR_RST_UP_HI, `TSR_RST_CONFIG}

// Configuration fields
`define TSR_CFG_RES_BIT 7
`define TSR_CFG_MODE_HI 6
`define TSR_CFG_MODE_LO 5
`define TSR_CFG_CMP_BIT 4
`define TSR_MODE_ONESHOT 2'b01
`define TSR_MODE_1SPS 2'b10

// Status fields
`define TSR_STAT_BOT_BIT 4
`define TSR_STAT_UP_BIT 5
`define TSR_STAT_SEV_BIT 6
`define TSR_STAT_RDYN_BIT 7

// Result flag positions in 13-bit resolution
`define TSR_FLAG_BOT_BIT 0
`define TSR_FLAG_UP_BIT 1
`define TSR_FLAG_SEV_BIT 2
`define TSR_COARSE_MASK 16'hfff8

// Margin is whole degrees; one degree is 128 result counts
`define TSR_MARGIN_SHIFT 7

`endif

// ===== tsr_byte.v
// One writable byte register with power-on and soft reset value
`timescale 1ns/1ps
`default_nettype none

module tsr_byte #(
	parameter [7:0] RESET_VAL = 8'h00
) (
	input wire clk_in,
	input wire reset_in,
	input wire clear_in,
	input wire load_in,
	input wire [7:0] data_in,
	output wire [7:0] value_out
);

	reg [7:0] value_ff; // Stored byte

	// Reset and soft clear load the default, else take a host write
	always @(posedge clk_in) begin
		if (reset_in || clear_in) begin
			value_ff <= RESET_VAL;
		end else if (load_in) begin
			value_ff <= data_in;
		end
	end

	assign value_out = value_ff;

endmodule // tsr_byte

`default_nettype wire

// ===== tsr_cmp.v
// Signed limit compare with hysteresis return point
`timescale 1ns/1ps
`default_nettype none

module tsr_cmp #(
	parameter ABOVE = 1
) (
	input wire [15:0] temp_in,
	input wire [15:0] limit_in,
	input wire [7:0] margin_in,
	output wire beyond_out,
	output wire settled_out
);

	wire signed [17:0] temp_s; // Sign-extended reading
	wire signed [17:0] limit_s; // Sign-extended limit
	wire signed [17:0] margin_s; // Margin in result counts
	wire signed [17:0] back_s; // Return point

	assign temp_s = {{2{temp_in[15]}}, temp_in};
	assign limit_s = {{2{limit_in[15]}}, limit_in};
	assign margin_s = {3'b000, margin_in, 7'b0000000};
	assign back_s = ABOVE ? (limit_s - margin_s) : (limit_s + margin_s);

	// Above-side limit trips high, below-side trips low
	assign beyond_out = ABOVE ? (temp_s > limit_s) : (temp_s < limit_s);
	assign settled_out = ABOVE ? (temp_s < back_s) : (temp_s > back_s);

endmodule // tsr_cmp

`default_nettype wire

// ===== tsr_regs.v
// Register bank of the temperature sensor behind a byte-wide host port
`timescale 1ns/1ps
`default_nettype none
`include "tsr_map.vh"

module tsr_regs #(
	parameter [7:0] IDENT_VAL = 8'h5a // Identity byte, value arbitrary
) (
	input wire clk_in,
	input wire reset_in,
	input wire host_start_in, // Pulse: a write transaction begins
	input wire host_wr_in, // Pulse: one byte written
	input wire [7:0] host_wdata_in, // Written byte
	input wire host_rd_in, // Pulse: one byte read
	input wire conv_valid_in, // Pulse: new conversion result
	input wire [15:0] conv_data_in, // 16-bit two's complement reading
	output wire [7:0] host_rdata_out, // Read byte
	output wire host_rvalid_out, // Pulse: read byte valid
	output wire [7:0] config_out, // Configuration byte
	output wire [7:0] status_out, // Status byte
	output wire mode_kick_out // Pulse: operation mode rewritten
);

	// Defaults of the writable bank, configuration byte lowest
	localparam [`TSR_NUM_WR*8-1:0] BANK_RST = `TSR_RST_WR_ALL;

	// Host-side state
	reg [7:0] pointer_bits_ff; // Register pointer
	reg [7:0] nxt_pointer_bits;
	reg first_byte_ff; // Next write is the pointer byte
	reg nxt_first_byte;
	reg [7:0] rdata_ff; // Read data
	reg [7:0] nxt_rdata;
	reg rvalid_ff; // Read data valid
	reg soft_clear_ff; // Soft reset pulse to writable bank
	reg kick_ff; // Mode write pulse

	// Measurement state
	reg [15:0] result_ff; // Stored result word
	reg [15:0] nxt_result;
	reg [2:0] alarm_ff; // Status alarms: severe, upper, bottom
	reg [2:0] nxt_alarm;
	reg ready_n_ff; // Active-low result pending
	reg nxt_ready_n;
	reg [7:0] status_byte; // Status byte as the host sees it

	// Decoded strobes
	wire data_wr; // Write of register data
	wire ptr_wr; // Write of the pointer
	wire read_now; // Read accepted this cycle
	wire soft_hit; // Write to soft reset location
	wire cfg_wr; // Write to configuration
	wire [`TSR_NUM_WR*8-1:0] wr_bank; // Writable bytes, packed
	wire [7:0] cfg_byte;
	wire [15:0] up_limit;
	wire [15:0] bot_limit;
	wire [15:0] sev_limit;
	wire [7:0] margin;
	wire [15:0] cmp_temp; // Reading as compared
	wire [2:0] beyond; // Severe, upper, bottom exceeded
	wire [2:0] settled; // Back inside with margin
	wire [1:0] new_mode; // Mode bits being written
	wire stat_rd; // Status byte read this cycle
	wire res_rd; // Result byte read this cycle
	wire [7:0] rst_status; // Power-on status image

	// Write of data only after the pointer byte
	assign ptr_wr = host_wr_in && (first_byte_ff || host_start_in);
	assign data_wr = host_wr_in && !ptr_wr;
	// A write in the same cycle takes priority over a read
	assign read_now = host_rd_in && !host_wr_in;
	assign soft_hit = data_wr && (pointer_bits_ff == `TSR_ADDR_SOFT_RST);
	assign cfg_wr = data_wr && (pointer_bits_ff == `TSR_ADDR_CONFIG);
	assign new_mode = host_wdata_in[`TSR_CFG_MODE_HI:`TSR_CFG_MODE_LO];
	// Reads that clear the alarms or raise the pending bit
	assign stat_rd = read_now && (pointer_bits_ff == `TSR_ADDR_STATUS);
	assign res_rd = read_now && ((pointer_bits_ff == `TSR_ADDR_RES_HI) ||
		(pointer_bits_ff == `TSR_ADDR_RES_LO));
	// Reset image of the status byte, one bit per flag
	assign rst_status = `TSR_RST_STATUS;

	// Writable bytes 0x03..0x0a, one instance each
	genvar gi;
	generate
		for (gi = 0; gi < `TSR_NUM_WR; gi = gi + 1) begin : g_wr
			wire hit; // This byte addressed
			assign hit = data_wr && (pointer_bits_ff == (`TSR_ADDR_CONFIG + gi));
			// Soft clear is a flop away from the write, so defaults land on the second edge
			tsr_byte #(
				.RESET_VAL(BANK_RST[gi*8 +: 8])
			) u_byte (
				.clk_in(clk_in),
				.reset_in(reset_in),
				.clear_in(soft_clear_ff),
				.load_in(hit),
				.data_in(host_wdata_in),
				.value_out(wr_bank[gi*8 +: 8])
			);
		end
	endgenerate

	// Unpack bank
	assign cfg_byte = wr_bank[7:0];
	assign up_limit = {wr_bank[15:8], wr_bank[23:16]};
	assign bot_limit = {wr_bank[31:24], wr_bank[39:32]};
	assign sev_limit = {wr_bank[47:40], wr_bank[55:48]};
	assign margin = wr_bank[63:56];

	// Coarse compare in 13-bit mode, full in 16-bit mode
	assign cmp_temp = cfg_byte[`TSR_CFG_RES_BIT] ? conv_data_in :
		(conv_data_in & `TSR_COARSE_MASK);

	// Limit compares
	tsr_cmp #(
		.ABOVE(1)
	) u_cmp_sev (
		.temp_in(cmp_temp),
		.limit_in(sev_limit),
		.margin_in(margin),
		.beyond_out(beyond[2]),
		.settled_out(settled[2])
	);

	tsr_cmp #(
		.ABOVE(1)
	) u_cmp_up (
		.temp_in(cmp_temp),
		.limit_in(up_limit),
		.margin_in(margin),
		.beyond_out(beyond[1]),
		.settled_out(settled[1])
	);

	tsr_cmp #(
		.ABOVE(0)
	) u_cmp_bot (
		.temp_in(cmp_temp),
		.limit_in(bot_limit),
		.margin_in(margin),
		.beyond_out(beyond[0]),
		.settled_out(settled[0])
	);

	// Pointer and transaction tracking
	always @* begin
		nxt_pointer_bits = pointer_bits_ff;
		nxt_first_byte = first_byte_ff;
		if (host_start_in) begin
			// New write transaction: first byte is pointer
			nxt_first_byte = 1'b1;
		end
		if (ptr_wr) begin
			// Full eight bits load the pointer
			nxt_pointer_bits = host_wdata_in;
			nxt_first_byte = 1'b0;
		end else if (data_wr || read_now) begin
			// Auto-increment after each data byte
			nxt_pointer_bits = pointer_bits_ff + 8'h01;
		end
		if (soft_hit) begin
			// Soft reset returns the pointer home
			nxt_pointer_bits = `TSR_RST_POINTER;
		end
	end

	// Read multiplexer over the sixteen locations
	always @* begin
		case (pointer_bits_ff)
			`TSR_ADDR_RES_HI: nxt_rdata = result_ff[15:8];
			`TSR_ADDR_RES_LO: nxt_rdata = result_ff[7:0];
			`TSR_ADDR_STATUS: nxt_rdata = status_out;
			`TSR_ADDR_IDENT: nxt_rdata = IDENT_VAL;
			`TSR_ADDR_CONFIG,
			`TSR_ADDR_UP_HI,
			`TSR_ADDR_UP_LO,
			`TSR_ADDR_BOT_HI,
			`TSR_ADDR_BOT_LO,
			`TSR_ADDR_SEV_HI,
			`TSR_ADDR_SEV_LO,
			`TSR_ADDR_MARGIN: nxt_rdata = wr_bank[(pointer_bits_ff - `TSR_ADDR_CONFIG) * 8 +: 8];
			// Reserved and soft reset read a fixed value
			default: nxt_rdata = `TSR_RSV_READ;
		endcase
	end

	// Result word, flags merged per resolution
	always @* begin
		nxt_result = result_ff;
		if (conv_valid_in) begin
			nxt_result = conv_data_in;
			if (!cfg_byte[`TSR_CFG_RES_BIT]) begin
				// 13-bit: low bits become flags
				nxt_result[2:0] = 3'b000;
				if (cfg_byte[`TSR_CFG_CMP_BIT]) begin
					// Comparator mode only, bit 4 set
					nxt_result[`TSR_FLAG_BOT_BIT] = beyond[0];
					nxt_result[`TSR_FLAG_UP_BIT] = beyond[1];
					nxt_result[`TSR_FLAG_SEV_BIT] = beyond[2];
				end
			end
			// 16-bit: low bits stay as reading bits
		end
	end

	// Status alarms: set wins over read clear
	always @* begin
		nxt_alarm = alarm_ff;
		if (stat_rd) begin
			nxt_alarm = 3'b000;
		end
		if (conv_valid_in) begin
			// Back inside limits less margin clears, new trip sets
			nxt_alarm = (nxt_alarm & ~settled) | beyond;
		end
	end

	// Pending bit, new result wins over raise
	always @* begin
		nxt_ready_n = ready_n_ff;
		if (res_rd) begin
			nxt_ready_n = 1'b1;
		end
		if (cfg_wr && ((new_mode == `TSR_MODE_ONESHOT) || (new_mode == `TSR_MODE_1SPS))) begin
			nxt_ready_n = 1'b1;
		end
		if (conv_valid_in) begin
			nxt_ready_n = 1'b0;
		end
	end

	// Host-side registers
	always @(posedge clk_in) begin
		if (reset_in) begin
			pointer_bits_ff <= `TSR_RST_POINTER;
			first_byte_ff <= 1'b0;
			rdata_ff <= 8'h00;
			rvalid_ff <= 1'b0;
			soft_clear_ff <= 1'b0;
			kick_ff <= 1'b0;
		end else begin
			pointer_bits_ff <= nxt_pointer_bits;
			first_byte_ff <= nxt_first_byte;
			rvalid_ff <= read_now;
			soft_clear_ff <= soft_hit;
			kick_ff <= cfg_wr;
			if (read_now) begin
				rdata_ff <= nxt_rdata;
			end
		end
	end

	// Measurement registers
	always @(posedge clk_in) begin
		if (reset_in) begin
			result_ff <= `TSR_RST_RESULT;
			alarm_ff <= rst_status[`TSR_STAT_SEV_BIT:`TSR_STAT_BOT_BIT];
			ready_n_ff <= rst_status[`TSR_STAT_RDYN_BIT];
		end else begin
			result_ff <= nxt_result;
			alarm_ff <= nxt_alarm;
			ready_n_ff <= nxt_ready_n;
		end
	end

	// Outputs straight from flops
	assign host_rdata_out = rdata_ff;
	assign host_rvalid_out = rvalid_ff;
	assign config_out = cfg_byte;
	// Status layout, low nibble zero
	assign status_out = status_byte;
	assign mode_kick_out = kick_ff;

	// Status flags placed at their field positions
	always @* begin
		status_byte = 8'h00; // Unused low bits read zero
		status_byte[`TSR_STAT_RDYN_BIT] = ready_n_ff;
		status_byte[`TSR_STAT_SEV_BIT] = alarm_ff[2];
		status_byte[`TSR_STAT_UP_BIT] = alarm_ff[1];
		status_byte[`TSR_STAT_BOT_BIT] = alarm_ff[0];
	end

endmodule // tsr_regs

`default_nettype wire

// ===== tsr_regs_monitor.sv
// Port checker for the sensor register bank
`timescale 1ns/1ps
`default_nettype none
module tsr_regs_monitor (
	input wire clk_in,
	input wire reset_in,
	input wire host_start_in,
	input wire host_wr_in,
	input wire [7:0] host_wdata_in,
	input wire host_rd_in,
	input wire conv_valid_in,
	input wire [15:0] conv_data_in,
	input wire [7:0] host_rdata_out,
	input wire host_rvalid_out,
	input wire [7:0] config_out,
	input wire [7:0] status_out,
	input wire mode_kick_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	property p_rv; host_rd_in && !host_wr_in |=> host_rvalid_out; endproperty
	a_rv: assert property (p_rv) else $error("read not answered");
	property p_norv; !host_rd_in || host_wr_in |=> !host_rvalid_out; endproperty
	a_norv: assert property (p_norv) else $error("stray read valid");
	property p_hold; !host_rvalid_out |-> $stable(host_rdata_out); endproperty
	a_hold: assert property (p_hold) else $error("read byte moved");
	property p_low; status_out[3:0] == 4'h0; endproperty
	a_low: assert property (p_low) else $error("status low bits set");
	property p_conv; conv_valid_in |=> !status_out[7]; endproperty
	a_conv: assert property (p_conv) else $error("pending not low");
	property p_rise; $rose(status_out[7]) |-> $past(host_rd_in) || $past(host_wr_in); endproperty
	a_rise: assert property (p_rise) else $error("pending rose alone");
	property p_trip; $rose(status_out[5]) |-> $past(conv_valid_in); endproperty
	a_trip: assert property (p_trip) else $error("alarm without conversion");
	property p_clr; $fell(status_out[5]) |-> $past(conv_valid_in) || $past(host_rd_in); endproperty
	a_clr: assert property (p_clr) else $error("alarm cleared alone");
	property p_cfg; !$past(host_wr_in) && !$past(host_wr_in, 2) |-> $stable(config_out); endproperty
	a_cfg: assert property (p_cfg) else $error("config moved alone");
	property p_kick; mode_kick_out |-> $past(host_wr_in); endproperty
	a_kick: assert property (p_kick) else $error("kick without write");
endmodule // tsr_regs_monitor
bind tsr_regs tsr_regs_monitor u_mon (.clk_in(clk_in), .reset_in(reset_in),
	.host_start_in(host_start_in), .host_wr_in(host_wr_in), .host_wdata_in(host_wdata_in),
	.host_rd_in(host_rd_in), .conv_valid_in(conv_valid_in), .conv_data_in(conv_data_in),
	.host_rdata_out(host_rdata_out), .host_rvalid_out(host_rvalid_out),
	.config_out(config_out), .status_out(status_out), .mode_kick_out(mode_kick_out));
`default_nettype wire

// ===== tsr_host_model.sv
// Host side model issuing byte writes and reads
`timescale 1ns/1ps
`default_nettype none
module tsr_host_model (
	input wire clk_in,
	input wire [7:0] rdata_in,
	input wire rvalid_in,
	output logic start_out,
	output logic wr_out,
	output logic [7:0] wdata_out,
	output logic rd_out
);
	// Idle bus
	initial begin
		start_out = 1'b0;
		wr_out = 1'b0;
		wdata_out = 8'h00;
		rd_out = 1'b0;
	end
	// One byte; with first set it is the pointer
	task send(input [7:0] b, input first);
		@(posedge clk_in);
		#1;
		start_out = first;
		wr_out = 1'b1;
		wdata_out = b;
		@(posedge clk_in);
		#1;
		start_out = 1'b0;
		wr_out = 1'b0;
		wdata_out = ~b; // Released data never keeps its value
	endtask
	// One byte read at the pointer, taken in the answer cycle
	task fetch(output [7:0] b, output v);
		@(posedge clk_in);
		#1;
		rd_out = 1'b1;
		@(posedge clk_in);
		#1;
		rd_out = 1'b0;
		b = rdata_in;
		v = rvalid_in;
	endtask
endmodule // tsr_host_model
`default_nettype wire

// ===== tsr_regs_tb.sv
// Self-checking bench of the sensor register bank
`timescale 1ns/1ps
`default_nettype none
module tsr_regs_tb;
	localparam [7:0] IDENT = 8'h3c; // Arbitrary identity value
	logic clk_in = 1'b0;
	logic reset_in; // Driven from the first instant by boot
	logic conv_valid_in = 1'b0;
	logic [15:0] conv_data_in = 16'h0000;
	wire host_start_in, host_wr_in, host_rd_in, host_rvalid_out, mode_kick_out;
	wire [7:0] host_wdata_in, host_rdata_out, config_out, status_out;
	integer mismatches = 0;
	integer check_count = 0;
	logic [7:0] e [0:13]; // Expected register image
	logic [2:0] al; // Expected alarms: severe, upper, bottom
	logic pend; // Expected pending bit
	logic [7:0] ptr; // Expected pointer
	logic [31:0] rnd;
	logic [7:0] cfg;
	integer i, j;
	tsr_regs #(.IDENT_VAL(IDENT)) dut (.clk_in(clk_in), .reset_in(reset_in),
		.host_start_in(host_start_in), .host_wr_in(host_wr_in), .host_wdata_in(host_wdata_in),
		.host_rd_in(host_rd_in), .conv_valid_in(conv_valid_in), .conv_data_in(conv_data_in),
		.host_rdata_out(host_rdata_out), .host_rvalid_out(host_rvalid_out),
		.config_out(config_out), .status_out(status_out), .mode_kick_out(mode_kick_out));
	tsr_host_model host (.clk_in(clk_in), .rdata_in(host_rdata_out), .rvalid_in(host_rvalid_out),
		.start_out(host_start_in), .wr_out(host_wr_in), .wdata_out(host_wdata_in),
		.rd_out(host_rd_in));
	initial begin
		forever #5 clk_in = ~clk_in;
	end
	task check(input [15:0] seen, input [15:0] want);
		check_count = check_count + 1;
		if (seen !== want) begin
			mismatches = mismatches + 1;
			$display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task conclude;
		if (mismatches == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Power-on value of each register
	function [7:0] rst_val(input integer a);
		case (a)
			4: rst_val = 8'h20;
			6: rst_val = 8'h05;
			8: rst_val = 8'h49;
			9: rst_val = 8'h80;
			10: rst_val = 8'h05;
			11: rst_val = IDENT;
			default: rst_val = 8'h00;
		endcase
	endfunction
	// Expected read byte at an address
	function [7:0] exp_at(input [7:0] a);
		if (a == 8'h02) exp_at = {pend, al, 4'h0};
		else if (a < 8'h0e) exp_at = e[a[3:0]];
		else exp_at = 8'h00;
	endfunction
	function [15:0] corner(input integer n);
		case (n)
			0: corner = 16'h0100;
			1: corner = 16'h3000;
			2: corner = 16'h5000;
			3: corner = 16'h2000;
			default: corner = 16'hf000;
		endcase
	endfunction
	// Image update for one data write at the pointer
	task upd(input [7:0] d);
		integer k;
		if (ptr > 8'h02 && ptr < 8'h0b) e[ptr[3:0]] = d;
		if (ptr == 8'h03 && (d[6:5] == 2'b01 || d[6:5] == 2'b10)) pend = 1'b1;
		if (ptr == 8'h2f) begin
			for (k = 3; k < 11; k = k + 1) e[k] = rst_val(k);
		end
		ptr = (ptr == 8'h2f) ? 8'h00 : ptr + 8'h01;
	endtask
	task put(input [7:0] a, input [7:0] d);
		host.send(a, 1'b1);
		ptr = a;
		host.send(d, 1'b0);
		upd(d);
	endtask
	// Reads n bytes from the current pointer and checks each
	task scan(input integer n);
		integer k;
		logic [7:0] b;
		logic v;
		for (k = 0; k < n; k = k + 1) begin
			host.fetch(b, v);
			check(v, 1'b1);
			check(b, exp_at(ptr));
			if (ptr < 8'h02) pend = 1'b1;
			if (ptr == 8'h02) al = 3'b000;
			ptr = ptr + 8'h01;
		end
	endtask
	task sweep(input [7:0] a, input integer n);
		host.send(a, 1'b1);
		ptr = a;
		scan(n);
	endtask
	// Reset for ten cycles, then read five bytes from the home pointer
	task boot;
		integer k;
		reset_in = 1'b1;
		for (k = 0; k < 14; k = k + 1) e[k] = rst_val(k);
		pend = 1'b0;
		al = 3'b000;
		ptr = 8'h00; // Expected home; no pointer write follows
		repeat (10) @(posedge clk_in);
		#1;
		reset_in = 1'b0;
		scan(5);
	endtask
	// New reading with expected flags and status
	task conv(input [15:0] d);
		logic [15:0] t;
		logic [15:0] m;
		logic [2:0] tr;
		logic [2:0] cl;
		t = e[3][7] ? d : d & 16'hfff8;
		m = {1'b0, e[10], 7'h00};
		tr[2] = $signed(t) > $signed({e[8], e[9]});
		tr[1] = $signed(t) > $signed({e[4], e[5]});
		tr[0] = $signed(t) < $signed({e[6], e[7]});
		cl[2] = $signed(t) < $signed({e[8], e[9]} - m);
		cl[1] = $signed(t) < $signed({e[4], e[5]} - m);
		cl[0] = $signed(t) > $signed({e[6], e[7]} + m);
		al = tr | (al & ~cl);
		pend = 1'b0;
		e[0] = d[15:8];
		e[1] = e[3][7] ? d[7:0] : {d[7:3], e[3][4] ? tr : 3'b000};
		@(posedge clk_in);
		#1;
		conv_valid_in = 1'b1;
		conv_data_in = d;
		@(posedge clk_in);
		#1;
		conv_valid_in = 1'b0;
		conv_data_in = ~d;
	endtask
	// Main sequence
	initial begin
		rnd = $urandom(43);
		boot;
		sweep(8'h00, 14);
		host.send(8'h00, 1'b1);
		ptr = 8'h00;
		for (i = 0; i < 14; i = i + 1) begin
			rnd = $urandom;
			host.send(rnd[7:0], 1'b0);
			upd(rnd[7:0]);
		end
		sweep(8'h00, 14);
		rnd = $urandom;
		put(8'h2f, rnd[7:0]);
		sweep(8'h2c, 4);
		for (i = 0; i < 3; i = i + 1) begin
			cfg = (i == 0) ? 8'h10 : (i == 1) ? 8'h00 : 8'h80;
			put(8'h03, cfg);
			for (j = 0; j < 8; j = j + 1) begin
				rnd = $urandom;
				conv(j < 5 ? corner(j) : rnd[15:0]);
				sweep(8'h00, 14);
			end
		end
		put(8'h03, 8'h10);
		conv(16'h3000);
		conv(16'h1f00);
		sweep(8'h02, 1);
		conv(16'h3000);
		conv(16'h1000);
		sweep(8'h02, 1);
		check(status_out, {pend, al, 4'h0});
		put(8'h03, 8'h30);
		check(status_out, {pend, al, 4'h0});
		check(config_out, 8'h30);
		check(mode_kick_out, 1'b1);
		conv(16'h1000);
		check(mode_kick_out, 1'b0);
		put(8'h03, 8'h40);
		check(status_out, {pend, al, 4'h0});
		boot;
		conclude;
	end
	initial begin
		#400000;
		mismatches = mismatches + 1;
		conclude;
	end
endmodule // tsr_regs_tb
`default_nettype wire
